// [src/rofm_pkg.sv]
// package: constants, types and register map of the relay output mapper
package rofm_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned ENERGY_PULSE_MS = 100;
  localparam int unsigned AIR_SHUTOFF_S   = 5;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned ENERGY_PULSE_CYC =
    (CLK_HZ / MS_PER_S) * ENERGY_PULSE_MS;
  localparam int unsigned AIR_SHUTOFF_CYC = CLK_HZ * AIR_SHUTOFF_S;

  // geometry
  localparam int NUM_RELAYS = 12;
  localparam int NUM_CFG    = 7;
  localparam int CODE_W     = 5;
  localparam int NODE_W     = 8;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;

  // register index map
  localparam logic [ADDR_W-1:0] REG_LOCK     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_COMMAND  = 8'h01;
  localparam logic [ADDR_W-1:0] REG_NODE_EXP = 8'h02;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h03;
  localparam logic [ADDR_W-1:0] REG_RELAYS   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CFG_BASE = 8'h08;

  // fields
  localparam int CFG_POL_BIT   = 8;
  localparam int LOCK_BIT      = 0;
  localparam int CMD_RESET_BIT = 0;
  localparam int ST_WARN   = 0;
  localparam int ST_SOFT   = 1;
  localparam int ST_HARD   = 2;
  localparam int ST_SILENT = 3;
  localparam int ST_AIR    = 4;
  localparam int ST_PULSE  = 5;
  localparam int ST_NODE   = 6;
  localparam int ST_LOCK   = 7;

  // function codes
  localparam logic [CODE_W-1:0] FN_NOT_USED   = 5'h01;
  localparam logic [CODE_W-1:0] FN_BUS_TRIP   = 5'h02;
  localparam logic [CODE_W-1:0] FN_PREGLOW    = 5'h03;
  localparam logic [CODE_W-1:0] FN_IDLE_RATED = 5'h04;
  localparam logic [CODE_W-1:0] FN_AIR_SHUT   = 5'h05;
  localparam logic [CODE_W-1:0] FN_IGNITION   = 5'h06;
  localparam logic [CODE_W-1:0] FN_SPD_RAISE  = 5'h07;
  localparam logic [CODE_W-1:0] FN_SPD_LOWER  = 5'h08;
  localparam logic [CODE_W-1:0] FN_VLT_RAISE  = 5'h09;
  localparam logic [CODE_W-1:0] FN_VLT_LOWER  = 5'h0A;
  localparam logic [CODE_W-1:0] FN_RUN        = 5'h0B;
  localparam logic [CODE_W-1:0] FN_KWH_PULSE  = 5'h0C;
  localparam logic [CODE_W-1:0] FN_AN3_ALARM  = 5'h0D;
  localparam logic [CODE_W-1:0] FN_AN4_ALARM  = 5'h0E;
  localparam logic [CODE_W-1:0] FN_GEN_ONLY   = 5'h0F;
  localparam logic [CODE_W-1:0] FN_KVA        = 5'h10;
  localparam logic [CODE_W-1:0] FN_AN3_PRE    = 5'h11;
  localparam logic [CODE_W-1:0] FN_AN4_PRE    = 5'h12;
  localparam logic [CODE_W-1:0] FN_WARNING    = 5'h13;
  localparam logic [CODE_W-1:0] FN_SOFT_SD    = 5'h14;
  localparam logic [CODE_W-1:0] FN_HARD_SD    = 5'h15;
  localparam logic [CODE_W-1:0] FN_NODE_MISM  = 5'h16;
  localparam logic [CODE_W-1:0] FN_SELF_TEST  = 5'h17;
  localparam logic [CODE_W-1:0] FN_MIN        = FN_NOT_USED;
  localparam logic [CODE_W-1:0] FN_MAX        = FN_SELF_TEST;

  // configurable channel numbers (zero based) and reset selections
  localparam int CFG_CHAN [NUM_CFG] = '{2, 3, 5, 7, 9, 10, 11};
  localparam logic [CODE_W-1:0] CFG_DEFAULT [NUM_CFG] =
    '{FN_NOT_USED, FN_BUS_TRIP, FN_PREGLOW, FN_IDLE_RATED,
      FN_WARNING, FN_SOFT_SD, FN_HARD_SD};
  localparam logic CFG_POL_DEFAULT = 1'b1;

  // fixed channels (zero based)
  localparam int CH_GEN_CLOSE = 0;
  localparam int CH_GEN_OPEN  = 1;
  localparam int CH_FUEL      = 4;
  localparam int CH_STARTER   = 6;
  localparam int CH_HORN      = 8;

  // commands from sequencing logic
  typedef struct packed {
    logic gen_breaker_close;
    logic gen_breaker_open;
    logic fuel_solenoid;
    logic starter;
    logic horn;
    logic bus_breaker_trip;
    logic preglow;
    logic idle_rated;
    logic ignition_enable;
    logic speed_raise;
    logic speed_lower;
    logic voltage_raise;
    logic voltage_lower;
  } rofm_cmd_type;

  // plant and alarm status
  typedef struct packed {
    logic engine_running;
    logic energy_increment;
    logic analog_three_alarm;
    logic analog_four_alarm;
    logic generator_only_supply;
    logic apparent_power_threshold_flag;
    logic analog_three_prewarn_flag;
    logic analog_four_prewarn_flag;
    logic warning_event;
    logic soft_shutdown_event;
    logic hard_shutdown_event;
    logic emergency_stop;
    logic overspeed;
    logic alarm_log_clear;
    logic reset_alarm_press;
  } rofm_status_type;

  typedef enum logic [1:0] {
    RA_ARMED    = 2'b01,
    RA_SILENCED = 2'b10
  } rofm_reset_state_type;

endpackage : rofm_pkg

// [src/rofm_relay_mapper.sv]
// relay output function mapper: twelve relay drivers and their settings
// Notes on behaviour
// RULE1 - channels 1,2,5,7,9 fixed: breaker close, open, fuel, starter, horn
// RULE2 - several channels may share one code; no error is flagged
// RULE3 - channels 3,4,6,8,10,11,12 each select a code, range 1 to 23
// RULE4 - code 23 energized whenever the controller runs out of reset
// RULE5 - code 22 active when seen node number differs from expected
// RULE6 - code 21 latches on hard shutdown until alarm cleared
// RULE7 - code 20 latches on soft or hard shutdown until alarm cleared
// RULE8 - code 19 latches on warning or higher until alarm cleared
// RULE9 - codes 17 and 18 show analog pre-alarm of inputs 3 and 4
// RULE10 - codes 13 and 14 show analog alarm of inputs 3 and 4
// RULE11 - code 16 active while apparent power exceeds threshold
// RULE12 - code 15 active while generator alone supplies load
// RULE13 - code 12 gives a 100 ms pulse per 100 kWh increment
// RULE14 - code 11 is the run relay, active while engine runs
// RULE15 - codes 7,8 speed bias, 9,10 voltage bias raise and lower pairs
// RULE16 - code 6 enables the external ignition controller
// RULE17 - code 5 on for exactly 5 s after e-stop or overspeed, no latch
// RULE18 - code 4 idle/rated governor command, code 3 glow plug pre-heat
// RULE19 - code 2 bus breaker trip, code 1 always inactive
// RULE20 - per-channel polarity, default energize when active
// RULE21 - selection writes ignored unless lock is set; reads always allowed
// RULE22 - reset-alarm: first press silences horn, second clears latches
// RULE23 - undefined codes leave channel inactive; all outputs off in reset (here such writes are ignored and the old selection stays)
// RULE24 - reset selections 1,2,3,4,19,20,21 for the configurable channels
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module rofm_relay_mapper #(
  parameter int unsigned PULSE_CYCLES = rofm_pkg::ENERGY_PULSE_CYC,
  parameter int unsigned AIR_CYCLES   = rofm_pkg::AIR_SHUTOFF_CYC
) (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                reset_i,
  // register port
  input  wire logic [rofm_pkg::ADDR_W-1:0]         reg_addr_i,
  input  wire logic [rofm_pkg::DATA_W-1:0]         reg_wdata_i,
  input  wire logic                                reg_wr_i,
  input  wire logic                                reg_rd_i,
  output logic      [rofm_pkg::DATA_W-1:0]         reg_rdata_o,
  // controller signals
  input  wire rofm_pkg::rofm_cmd_type              cmd_i,
  input  wire rofm_pkg::rofm_status_type           status_i,
  input  wire logic [rofm_pkg::NODE_W-1:0]         node_seen_i,
  // relay drivers
  output logic      [rofm_pkg::NUM_RELAYS-1:0]     relay_o
);
  import rofm_pkg::*;

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int AW = $clog2(AIR_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYCLES);
  localparam logic [AW-1:0] AIR_LOAD   = AW'(AIR_CYCLES);
  localparam logic [PW-1:0] PULSE_ONE  = PW'(1);
  localparam logic [AW-1:0] AIR_ONE    = AW'(1);

  // configuration state
  logic [CODE_W-1:0]      sel_code_r [NUM_CFG];
  logic                   sel_pol_r  [NUM_CFG];
  logic                   lock_r;
  logic [NODE_W-1:0]      node_exp_r;

  // alarm state
  logic                   warn_r;
  logic                   soft_r;
  logic                   hard_r;
  logic                   silence_r;
  rofm_reset_state_type   ra_state_r;
  logic                   ra_clear;
  logic                   ra_press;
  logic                   sw_press_r;

  // timers
  logic [PW-1:0]          pulse_cnt_r;
  logic [AW-1:0]          air_cnt_r;
  logic                   air_trig_d_r;
  logic                   air_trig;
  logic                   run_r;
  logic                   node_mism;

  // function vector and output
  logic [(1<<CODE_W)-1:0] fn_vec;
  logic [NUM_RELAYS-1:0]  relay_nxt;
  logic [DATA_W-1:0]      rdata_nxt;

  logic                   wr_cfg;
  logic [ADDR_W-1:0]      cfg_idx;
  assign cfg_idx = reg_addr_i - REG_CFG_BASE;
  assign wr_cfg  = reg_wr_i && (reg_addr_i >= REG_CFG_BASE) &&
                   (cfg_idx < ADDR_W'(NUM_CFG));

  // lock and expected node number
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lock_r     <= 1'b0;
      node_exp_r <= '0;
    end else if (reg_wr_i && reg_addr_i == REG_LOCK) begin
      lock_r <= reg_wdata_i[LOCK_BIT];
    end else if (reg_wr_i && reg_addr_i == REG_NODE_EXP) begin
      node_exp_r <= reg_wdata_i[NODE_W-1:0];
    end
  end

  // channel selections: only while locked and code in range
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        sel_code_r[k] <= CFG_DEFAULT[k]; // [RULE24]
        sel_pol_r[k]  <= CFG_POL_DEFAULT; // [RULE20]
      end
    end else if (wr_cfg && lock_r && // [RULE21]
                 reg_wdata_i[CODE_W-1:0] >= FN_MIN &&
                 reg_wdata_i[CODE_W-1:0] <= FN_MAX) begin      // [RULE3]
      sel_code_r[cfg_idx[2:0]] <= reg_wdata_i[CODE_W-1:0];
      sel_pol_r[cfg_idx[2:0]]  <= reg_wdata_i[CFG_POL_BIT];
    end
  end

  // software reset-alarm press
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sw_press_r <= 1'b0;
    end else begin
      sw_press_r <= reg_wr_i && reg_addr_i == REG_COMMAND &&
                    reg_wdata_i[CMD_RESET_BIT];
    end
  end

  assign ra_press = status_i.reset_alarm_press || sw_press_r;
  assign ra_clear = ra_press && ra_state_r == RA_SILENCED;      // [RULE22]

  // two-step reset-alarm sequence
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ra_state_r <= RA_ARMED;
      silence_r  <= 1'b0;
    end else begin
      case (ra_state_r)
        RA_ARMED: begin
          if (ra_press) begin
            ra_state_r <= RA_SILENCED;
            silence_r  <= 1'b1; // [RULE22]
          end
        end
        RA_SILENCED: begin
          if (ra_press) begin
            ra_state_r <= RA_ARMED;
            silence_r  <= 1'b0;
          end
        end
        default: begin
          ra_state_r <= RA_ARMED;
          silence_r  <= 1'b0;
        end
      endcase
    end
  end

  // latched alarm indications; a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      warn_r <= 1'b0;
      soft_r <= 1'b0;
      hard_r <= 1'b0;
    end else begin
      if (status_i.hard_shutdown_event) begin
        hard_r <= 1'b1; // [RULE6]
      end else if (status_i.alarm_log_clear || ra_clear) begin
        hard_r <= 1'b0;
      end
      if (status_i.soft_shutdown_event ||
          status_i.hard_shutdown_event) begin
        soft_r <= 1'b1; // [RULE7]
      end else if (status_i.alarm_log_clear || ra_clear) begin
        soft_r <= 1'b0;
      end
      if (status_i.warning_event || status_i.soft_shutdown_event ||
          status_i.hard_shutdown_event) begin
        warn_r <= 1'b1; // [RULE8]
      end else if (status_i.alarm_log_clear || ra_clear) begin
        warn_r <= 1'b0;
      end
    end
  end

  // energy pulse timer, restarted by each increment
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pulse_cnt_r <= '0;
    end else if (status_i.energy_increment) begin
      pulse_cnt_r <= PULSE_LOAD; // [RULE13]
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - PULSE_ONE;
    end
  end

  // air shutoff timer: starts on a rising trigger, never latches
  assign air_trig = status_i.emergency_stop || status_i.overspeed;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      air_trig_d_r <= 1'b0;
      air_cnt_r    <= '0;
    end else begin
      air_trig_d_r <= air_trig;
      if (air_trig && !air_trig_d_r && air_cnt_r == '0) begin
        air_cnt_r <= AIR_LOAD; // [RULE17]
      end else if (air_cnt_r != '0) begin
        air_cnt_r <= air_cnt_r - AIR_ONE; // [RULE17]
      end
    end
  end

  // self-test level: high from the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1; // [RULE4]
    end
  end

  assign node_mism = node_seen_i != node_exp_r; // [RULE5]

  // function code to active level
  always_comb begin
    fn_vec                = '0; // [RULE23]
    fn_vec[FN_NOT_USED]   = 1'b0; // [RULE19]
    fn_vec[FN_BUS_TRIP]   = cmd_i.bus_breaker_trip; // [RULE19]
    fn_vec[FN_PREGLOW]    = cmd_i.preglow; // [RULE18]
    fn_vec[FN_IDLE_RATED] = cmd_i.idle_rated; // [RULE18]
    fn_vec[FN_AIR_SHUT]   = air_cnt_r != '0; // [RULE17]
    fn_vec[FN_IGNITION]   = cmd_i.ignition_enable; // [RULE16]
    fn_vec[FN_SPD_RAISE]  = cmd_i.speed_raise &&
                            !cmd_i.speed_lower; // [RULE15]
    fn_vec[FN_SPD_LOWER]  = cmd_i.speed_lower &&
                            !cmd_i.speed_raise; // [RULE15]
    fn_vec[FN_VLT_RAISE]  = cmd_i.voltage_raise &&
                            !cmd_i.voltage_lower; // [RULE15]
    fn_vec[FN_VLT_LOWER]  = cmd_i.voltage_lower &&
                            !cmd_i.voltage_raise; // [RULE15]
    fn_vec[FN_RUN]        = status_i.engine_running; // [RULE14]
    fn_vec[FN_KWH_PULSE]  = pulse_cnt_r != '0; // [RULE13]
    fn_vec[FN_AN3_ALARM]  = status_i.analog_three_alarm; // [RULE10]
    fn_vec[FN_AN4_ALARM]  = status_i.analog_four_alarm; // [RULE10]
    fn_vec[FN_GEN_ONLY]   = status_i.generator_only_supply; // [RULE12]
    fn_vec[FN_KVA]        =
      status_i.apparent_power_threshold_flag; // [RULE11]
    fn_vec[FN_AN3_PRE]    = status_i.analog_three_prewarn_flag; // [RULE9]
    fn_vec[FN_AN4_PRE]    = status_i.analog_four_prewarn_flag;  // [RULE9]
    fn_vec[FN_WARNING]    = warn_r; // [RULE8]
    fn_vec[FN_SOFT_SD]    = soft_r; // [RULE7]
    fn_vec[FN_HARD_SD]    = hard_r; // [RULE6]
    fn_vec[FN_NODE_MISM]  = node_mism; // [RULE5]
    fn_vec[FN_SELF_TEST]  = run_r; // [RULE4]
  end

  // relay levels: fixed channels, then configurable ones
  always_comb begin
    relay_nxt               = '0;
    relay_nxt[CH_GEN_CLOSE] = cmd_i.gen_breaker_close; // [RULE1]
    relay_nxt[CH_GEN_OPEN]  = cmd_i.gen_breaker_open; // [RULE1]
    relay_nxt[CH_FUEL]      = cmd_i.fuel_solenoid; // [RULE1]
    relay_nxt[CH_STARTER]   = cmd_i.starter; // [RULE1]
    relay_nxt[CH_HORN]      = cmd_i.horn && !silence_r; // [RULE22]
    // each channel reads its own selection; sharing a code is legal
    for (int k = 0; k < NUM_CFG; k++) begin
      relay_nxt[CFG_CHAN[k]] =
        (fn_vec[sel_code_r[k]] == sel_pol_r[k]); // [RULE20] [RULE2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      relay_o <= '0; // [RULE23]
    end else begin
      relay_o <= relay_nxt;
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = '0;
    if (reg_addr_i == REG_LOCK) begin
      rdata_nxt[LOCK_BIT] = lock_r;
    end else if (reg_addr_i == REG_NODE_EXP) begin
      rdata_nxt[NODE_W-1:0] = node_exp_r;
    end else if (reg_addr_i == REG_STATUS) begin
      rdata_nxt[ST_WARN]   = warn_r;
      rdata_nxt[ST_SOFT]   = soft_r;
      rdata_nxt[ST_HARD]   = hard_r;
      rdata_nxt[ST_SILENT] = silence_r;
      rdata_nxt[ST_AIR]    = air_cnt_r != '0;
      rdata_nxt[ST_PULSE]  = pulse_cnt_r != '0;
      rdata_nxt[ST_NODE]   = node_mism;
      rdata_nxt[ST_LOCK]   = lock_r;
    end else if (reg_addr_i == REG_RELAYS) begin
      rdata_nxt[NUM_RELAYS-1:0] = relay_o;
    end else if (reg_addr_i >= REG_CFG_BASE &&
                 cfg_idx < ADDR_W'(NUM_CFG)) begin
      rdata_nxt[CODE_W-1:0]  = sel_code_r[cfg_idx[2:0]];
      rdata_nxt[CFG_POL_BIT] = sel_pol_r[cfg_idx[2:0]];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt; // [RULE21]
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : rofm_relay_mapper

// [test/rofm_relay_load.sv]
// relay driver load model: contacts follow drive, closure length measured
`timescale 1ns/1ps
module rofm_relay_load #(
  parameter int CH = 2
) (
  // clock
  input  wire logic                            clk_i,
  // relay drive
  input  wire logic [rofm_pkg::NUM_RELAYS-1:0] relay_i,
  // contact state and length of the last closure of one channel
  output logic      [rofm_pkg::NUM_RELAYS-1:0] contact_o,
  output int                                   last_len_o
);
  int run_r;
  assign contact_o = relay_i;
  always @(posedge clk_i) begin
    if (relay_i[CH]) begin
      run_r <= run_r + 1;
    end else begin
      if (run_r != 0) last_len_o <= run_r;
      run_r <= 0;
    end
  end
endmodule : rofm_relay_load

// [test/rofm_relay_mapper_checker.sv]
// checker: port-level assertions for the relay output mapper
`timescale 1ns/1ps
module rofm_relay_mapper_checker #(
  parameter int unsigned PULSE_CYCLES = 10,
  parameter int unsigned AIR_CYCLES   = 20
) (
  // clock and reset
  input wire logic                            clk_i,
  input wire logic                            reset_i,
  // register port
  input wire logic [rofm_pkg::ADDR_W-1:0]     reg_addr_i,
  input wire logic [rofm_pkg::DATA_W-1:0]     reg_wdata_i,
  input wire logic                            reg_wr_i,
  input wire logic                            reg_rd_i,
  input wire logic [rofm_pkg::DATA_W-1:0]     reg_rdata_o,
  // controller signals and relays
  input wire rofm_pkg::rofm_cmd_type          cmd_i,
  input wire rofm_pkg::rofm_status_type       status_i,
  input wire logic [rofm_pkg::NODE_W-1:0]     node_seen_i,
  input wire logic [rofm_pkg::NUM_RELAYS-1:0] relay_o
);
  import rofm_pkg::*;
  logic                  lock_r;
  logic                  touched_r;
  logic                  rst_r;
  logic                  rd_r;
  logic [ADDR_W-1:0]     addr_r;
  logic [NUM_RELAYS-1:0] relay_r;
  rofm_cmd_type          cmd_r;

  // lock shadow and any channel setting write made under lock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lock_r    <= 1'b0;
      touched_r <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_LOCK) lock_r <= reg_wdata_i[LOCK_BIT];
      if (lock_r && reg_addr_i >= REG_CFG_BASE && reg_addr_i < 8'h0F)
        touched_r <= 1'b1;
    end
  end

  // one-cycle history of ports
  always_ff @(posedge clk_i) begin
    rst_r   <= reset_i;
    rd_r    <= reg_rd_i;
    addr_r  <= reg_addr_i;
    relay_r <= relay_o;
    cmd_r   <= cmd_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_event(ev);
    !touched_r && ev;
  endsequence
  property p_latch(ev, out);
    s_event(ev) |-> ##2 out;
  endproperty

  release_off_a: assert property ($fell(reset_i) |-> !relay_o)
    else $error("relay drive not off at reset release");
  rdata_idle_a: assert property (!rd_r |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read answer");
  fixed_path_a: assert property (!rst_r |->
    {relay_o[CH_GEN_CLOSE], relay_o[CH_GEN_OPEN], relay_o[CH_FUEL],
     relay_o[CH_STARTER]} == {cmd_r.gen_breaker_close,
     cmd_r.gen_breaker_open, cmd_r.fuel_solenoid, cmd_r.starter})
    else $error("fixed channel does not follow its command");
  horn_source_a: assert property (relay_o[CH_HORN] |-> cmd_r.horn)
    else $error("horn relay on without horn command");
  default_map_a: assert property (!touched_r && !rst_r |->
    !relay_o[2] && relay_o[3] == cmd_r.bus_breaker_trip &&
    relay_o[5] == cmd_r.preglow && relay_o[7] == cmd_r.idle_rated)
    else $error("default channel functions wrong");
  relay_read_a: assert property (rd_r && addr_r == REG_RELAYS |->
    reg_rdata_o == {4'h0, relay_r})
    else $error("relay readback wrong");
  unmapped_read_a: assert property (rd_r && (addr_r > 8'h0E ||
    addr_r inside {8'h01, 8'h05, 8'h06, 8'h07}) |-> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  lock_read_a: assert property (rd_r && addr_r == REG_LOCK |->
    reg_rdata_o == {15'h0000, lock_r})
    else $error("lock readback wrong");
  hard_latch_a: assert property (
    p_latch(status_i.hard_shutdown_event, relay_o[11]))
    else $error("hard shutdown relay not set");
  soft_latch_a: assert property (
    p_latch(status_i.soft_shutdown_event ||
    status_i.hard_shutdown_event, relay_o[10]))
    else $error("soft shutdown relay not set");
  warn_latch_a: assert property (p_latch(status_i.warning_event ||
    status_i.soft_shutdown_event || status_i.hard_shutdown_event, relay_o[9]))
    else $error("warning relay not set");
endmodule : rofm_relay_mapper_checker

bind rofm_relay_mapper rofm_relay_mapper_checker #(
  .PULSE_CYCLES(PULSE_CYCLES),
  .AIR_CYCLES(AIR_CYCLES)
) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cmd_i(cmd_i), .status_i(status_i),
  .node_seen_i(node_seen_i), .relay_o(relay_o)
);

// [test/rofm_relay_mapper_tb.sv]
// self-checking testbench for the relay output mapper
`timescale 1ns/1ps
module rofm_relay_mapper_tb;
  import rofm_pkg::*;
  localparam int unsigned PULSE_N = 10;
  localparam int unsigned AIR_N   = 20;
  localparam logic [11:0] CFG_MASK = 12'hEAC;
  localparam logic [4:0] CODES [18] = '{FN_BUS_TRIP, FN_PREGLOW,
    FN_IDLE_RATED, FN_IGNITION, FN_SPD_RAISE, FN_SPD_LOWER, FN_VLT_RAISE,
    FN_VLT_LOWER, FN_RUN, FN_AN3_ALARM, FN_AN4_ALARM, FN_GEN_ONLY, FN_KVA,
    FN_AN3_PRE, FN_AN4_PRE, FN_NODE_MISM, FN_SELF_TEST, FN_NOT_USED};
  logic                  clk;
  logic                  reset;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdata;
  logic                  wr;
  logic                  rd;
  logic [DATA_W-1:0]     rdata;
  rofm_cmd_type          cmd;
  rofm_status_type       st;
  logic [NODE_W-1:0]     node;
  logic [NUM_RELAYS-1:0] relay;
  int                    last_len;
  int                    n_mismatch;
  int                    cmp_count;
  int                    cycles;

  rofm_relay_mapper #(.PULSE_CYCLES(PULSE_N), .AIR_CYCLES(AIR_N)) dut (
    .clk_i(clk), .reset_i(reset), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cmd_i(cmd),
    .status_i(st), .node_seen_i(node), .relay_o(relay));
  rofm_relay_load #(.CH(2)) load (.clk_i(clk), .relay_i(relay),
    .contact_o(), .last_len_o(last_len));

  always #12.5 clk = ~clk;

  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
  endtask : rd_chk

  task automatic chk_relay(input logic [11:0] mask, input logic [11:0] exp);
    tick(3);
    chk({4'h0, relay & mask}, {4'h0, exp});
  endtask : chk_relay

  task automatic set_all(input logic [4:0] code, input logic pol);
    for (int i = 0; i < NUM_CFG; i++)
      wr_reg(8'(REG_CFG_BASE + i), {7'h00, pol, 3'h0, code});
  endtask : set_all

  task automatic drive(input logic [4:0] code, input logic on);
    case (code)
      FN_BUS_TRIP:   cmd.bus_breaker_trip <= on;
      FN_PREGLOW:    cmd.preglow <= on;
      FN_IDLE_RATED: cmd.idle_rated <= on;
      FN_IGNITION:   cmd.ignition_enable <= on;
      FN_SPD_RAISE:  cmd.speed_raise <= on;
      FN_SPD_LOWER:  cmd.speed_lower <= on;
      FN_VLT_RAISE:  cmd.voltage_raise <= on;
      FN_VLT_LOWER:  cmd.voltage_lower <= on;
      FN_RUN:        st.engine_running <= on;
      FN_AN3_ALARM:  st.analog_three_alarm <= on;
      FN_AN4_ALARM:  st.analog_four_alarm <= on;
      FN_GEN_ONLY:   st.generator_only_supply <= on;
      FN_KVA:        st.apparent_power_threshold_flag <= on;
      FN_AN3_PRE:    st.analog_three_prewarn_flag <= on;
      FN_AN4_PRE:    st.analog_four_prewarn_flag <= on;
      FN_NODE_MISM:  node <= on ? 8'h05 : 8'h00;
      default: ;
    endcase
  endtask : drive

  task automatic t_fixed();
    int ch [5] = '{CH_GEN_CLOSE, CH_GEN_OPEN, CH_FUEL, CH_STARTER, CH_HORN};
    for (int i = 0; i < 5; i++) begin
      cmd <= rofm_cmd_type'(13'h1000 >> i);
      chk_relay(12'hFFF, 12'(1 << ch[i]));
    end
    cmd <= '0;
    chk_relay(12'hFFF, 12'h000);
  endtask : t_fixed

  task automatic t_latch();
    cmd.horn <= 1'b1;
    st.warning_event <= 1'b1;
    tick(1);
    st.warning_event <= 1'b0;
    chk_relay(12'hF00, 12'h300);
    st.alarm_log_clear <= 1'b1;
    tick(1);
    st.alarm_log_clear <= 1'b0;
    chk_relay(12'hF00, 12'h100);
    st.soft_shutdown_event <= 1'b1;
    tick(1);
    st.soft_shutdown_event <= 1'b0;
    tick(5);
    chk_relay(12'hF00, 12'h700);
    st.hard_shutdown_event <= 1'b1;
    tick(1);
    st.hard_shutdown_event <= 1'b0;
    chk_relay(12'hF00, 12'hF00);
    rd_chk(REG_STATUS, 16'h0007);
    rd_chk(REG_RELAYS, 16'h0F00);
    st.reset_alarm_press <= 1'b1;
    tick(1);
    st.reset_alarm_press <= 1'b0;
    chk_relay(12'hF00, 12'hE00);
    wr_reg(REG_COMMAND, 16'h0001);
    chk_relay(12'hF00, 12'h100);
    cmd.horn <= 1'b0;
    tick(1);
  endtask : t_latch

  task automatic t_cfg();
    for (int i = 0; i < NUM_CFG; i++)
      rd_chk(8'(REG_CFG_BASE + i),
             {8'h01, 3'h0, CFG_DEFAULT[i]});
    wr_reg(REG_CFG_BASE, 16'h010B);
    rd_chk(REG_CFG_BASE, 16'h0101);
    wr_reg(REG_LOCK, 16'h0001);
    rd_chk(REG_LOCK, 16'h0001);
    wr_reg(REG_CFG_BASE, 16'h0100);
    wr_reg(REG_CFG_BASE, 16'h0118);
    rd_chk(REG_CFG_BASE, 16'h0101);
    wr_reg(REG_CFG_BASE, 16'h0115);
    rd_chk(REG_CFG_BASE, 16'h0115);
    rd_chk(8'h05, 16'h0000);
    rd_chk(8'h0F, 16'h0000);
  endtask : t_cfg

  task automatic t_codes();
    foreach (CODES[k]) begin
      set_all(CODES[k], 1'b1);
      drive(CODES[k], 1'b0);
      chk_relay(CFG_MASK,
        {12{CODES[k] == FN_SELF_TEST}} & CFG_MASK);
      drive(CODES[k], 1'b1);
      chk_relay(CFG_MASK,
        {12{CODES[k] != FN_NOT_USED}} & CFG_MASK);
      drive(CODES[k], 1'b0);
    end
  endtask : t_codes

  task automatic t_pol();
    wr_reg(REG_CFG_BASE, 16'h0001);
    chk_relay(12'h004, 12'h004);
    wr_reg(REG_CFG_BASE, 16'h000B);
    st.engine_running <= 1'b1;
    chk_relay(12'h004, 12'h000);
    st.engine_running <= 1'b0;
    chk_relay(12'h004, 12'h004);
  endtask : t_pol

  task automatic t_timed();
    wr_reg(REG_CFG_BASE, 16'h010C);
    st.energy_increment <= 1'b1;
    tick(1);
    st.energy_increment <= 1'b0;
    tick(PULSE_N + 10);
    chk(16'(last_len), 16'(PULSE_N));
    wr_reg(REG_CFG_BASE, 16'h0105);
    st.emergency_stop <= 1'b1;
    tick(AIR_N + 10);
    chk(16'(last_len), 16'(AIR_N));
    chk({15'h0000, relay[2]}, 16'h0000);
    st.emergency_stop <= 1'b0;
    tick(2);
    st.overspeed <= 1'b1;
    chk_relay(12'h004, 12'h004);
    tick(AIR_N + 10);
    chk({15'(last_len), relay[2]}, {15'(AIR_N), 1'b0});
    st.overspeed <= 1'b0;
  endtask : t_timed

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    cmd = '0;
    st = '0;
    node = '0;
    repeat (16) @(posedge clk);
    chk({4'h0, relay}, 16'h0000);
    reset <= 1'b0;
    tick(2);
    t_fixed();
    t_latch();
    t_cfg();
    t_codes();
    t_pol();
    t_timed();
    final_report();
  end
endmodule : rofm_relay_mapper_tb
